// ===== dca_pkg.sv
`default_nettype none
package dca_pkg;

    // Conversion result width and straight-binary step (supply / 4096)
    localparam int RES_W = 12;
    localparam int CODE_STEPS = 4096;

    // Control word layout, shifted in MSB first
    localparam int CW_W = 8;
    localparam int CW_SEL_LO = 3;
    localparam int CW_SEL_MID = 4;
    localparam int CW_SEL_HI = 5;

    // Serial clock positions inside one conversion
    localparam logic [4:0] CLK_NONE = 5'h00;
    localparam logic [4:0] CLK_FIRST = 5'h01;
    localparam logic [4:0] CLK_HOLD = 5'h04;
    localparam logic [4:0] CLK_DATA = 5'h05;
    localparam logic [4:0] CLK_LAST = 5'h10;
    localparam logic [3:0] RISE_ZERO = 4'h0;
    localparam logic [3:0] RISE_ONE = 4'h1;
    localparam logic [3:0] WORD_LAST = 4'h7;

    // Channel codes and reset values
    localparam logic CHAN_A = 1'b0;
    localparam logic CHAN_B = 1'b1;
    localparam logic [7:0] CW_RESET = 8'h00;
    localparam logic [RES_W-1:0] CODE_ZERO = 12'h000;

    // Result buffer shape
    localparam int BUF_DEPTH = 2;

    typedef logic [RES_W-1:0] dca_code_t;

    // Converter phase inside a frame
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_TRACK = 2'b01,
        PH_CONV = 2'b10,
        PH_DOWN = 2'b11
    } dca_phase_e;

endpackage
`default_nettype wire

// ===== dca_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dca_buf_if;
    import dca_pkg::*;
    logic in_valid;
    logic in_ready;
    dca_code_t in_data;
    logic out_valid;
    logic out_ready;
    dca_code_t out_data;

    // Buffer side
    modport store (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    // Producer and consumer side
    modport user (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data
    );
endinterface
`default_nettype wire

// ===== dca_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
module dca_fifo2 import dca_pkg::*; #(
    parameter int W = RES_W,
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Buffer ports
    dca_buf_if.store b
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
        logic rdy;
    } fifo_s;

    fifo_s s_q;
    fifo_s s_d;
    logic push;
    logic pop;

    // Next state: write, read, count and registered ready
    always_comb begin
        s_d = s_q;
        push = b.in_valid & s_q.rdy;
        pop = b.out_ready & (s_q.cnt != '0);
        if (push) begin
            s_d.mem[s_q.wp] = b.in_data;
            s_d.wp = (s_q.wp == PTR_LAST) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == PTR_LAST) ? '0 : s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
        s_d.rdy = (s_d.cnt != CNT_FULL);
        if (!ce) begin
            s_d = s_q;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Handshake outputs
    assign b.in_ready = s_q.rdy & ce;
    assign b.out_valid = (s_q.cnt != '0);
    assign b.out_data = s_q.mem[s_q.rp];
endmodule
`default_nettype wire

// ===== dca_serial_ctrl.sv
// How it works
// [RULE1] Host sends, during each conversion, the channel for the following one.
// [RULE2] Frame select and clock falling together: next rising edge samples first.
// [RULE3] No start-up delay; the very first frame converts fully.
// [RULE4] First result after power-up always comes from input A.
// [RULE5] Channel taken from control word bits 5..3; other bits ignored.
// [RULE6] Channel bits 00 select input A, 01 input B; top bit ignored.
// [RULE7] Host never sets middle channel bit; output is then undefined.
// [RULE8] Results are 12-bit unsigned straight binary, step supply/4096.
// [RULE9] Powered up while frame select low, down while it is high.
// [RULE10] Power-down after 16th falling edge until next conversion's first.
// [RULE11] Back-to-back conversions of 16 clocks while frame select low.
// [RULE12] Host keeps serial clock at or below 8 MHz.
// [RULE13] Host gives each frame a multiple of 16 rising edges.
// [RULE14] Serial input sampled on first 8 rising edges of each conversion.
// [RULE15] Serial output released while frame select high, driven while low.
// [RULE16] Track three clocks, then convert; data MSB first from 5th clock.
// [RULE17] Control word shifted MSB first: bit 7 first, bit 0 eighth.
`timescale 1ns/1ps
`default_nettype none
module dca_serial_ctrl import dca_pkg::*; (
    // Clock, reset and enable
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic CE,
    // Serial pins
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic DIN,
    output logic DOUT,
    output logic DOUT_OE,
    // Sample request to the converter core
    output logic SAMPLE_REQ,
    output logic SAMPLE_CHAN,
    // Conversion results from the converter core
    input wire logic RESULT_VALID,
    input wire logic [RES_W-1:0] RESULT_CODE,
    output logic RESULT_READY,
    // Status
    output logic POWERED,
    output logic TRACKING
);

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_p;
        logic sck_s1;
        logic sck_s2;
        logic sck_p;
        logic din_s1;
        logic din_s2;
        logic [3:0] rise_cnt;
        logic [4:0] fall_cnt;
        logic [CW_W-1:0] word;
        logic chan;
        dca_code_t shift;
        dca_phase_e phase;
        logic dout;
        logic oe;
        logic pwr;
        logic track;
        logic req;
        logic req_chan;
        logic seen_req;
        logic rdy;
    } ctl_s;

    ctl_s s_q;
    ctl_s s_d;
    logic cs_low;
    logic cs_fell;
    logic rise;
    logic fall;
    logic pop;
    logic [4:0] kfall;
    logic [CW_W-1:0] wnext;

    dca_buf_if bif ();

    // Two-entry result buffer between converter core and shifter
    dca_fifo2 #(
        .W(RES_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(CORE_CLK),
        .rst(RESET),
        .ce(CE),
        .b(bif.store)
    );

    // Buffer connections
    assign bif.in_valid = RESULT_VALID & s_q.rdy; // Only what ready promised
    assign bif.in_data = RESULT_CODE;
    assign bif.out_ready = pop;

    // Pin sampling, edge finding and conversion sequencing
    always_comb begin
        s_d = s_q;
        pop = 1'b0;
        s_d.req = 1'b0;
        s_d.cs_s1 = CS_N;
        s_d.cs_s2 = s_q.cs_s1;
        s_d.cs_p = s_q.cs_s2;
        s_d.sck_s1 = SCLK;
        s_d.sck_s2 = s_q.sck_s1;
        s_d.sck_p = s_q.sck_s2;
        s_d.din_s1 = DIN;
        s_d.din_s2 = s_q.din_s1;
        cs_low = ~s_q.cs_s2;
        cs_fell = s_q.cs_p & ~s_q.cs_s2;
        rise = cs_low & s_q.sck_s2 & ~s_q.sck_p;
        // Frame start with clock low counts as the first falling edge
        fall = cs_low & ~s_q.sck_s2 & (s_q.sck_p | cs_fell); // RULE2
        kfall = ((s_q.fall_cnt == CLK_LAST) || (s_q.fall_cnt == CLK_NONE))
            ? CLK_FIRST : s_q.fall_cnt + 5'h01;
        wnext = {s_q.word[CW_W-2:0], s_q.din_s2};
        if (!cs_low) begin
            // Frame closed: counters cleared, output released
            s_d.rise_cnt = RISE_ZERO;
            s_d.fall_cnt = CLK_NONE;
            s_d.phase = PH_IDLE;
            s_d.oe = 1'b0; // RULE15
            s_d.dout = 1'b0;
            s_d.track = 1'b0;
        end else begin
            s_d.oe = 1'b1; // RULE15
            if (rise) begin
                s_d.rise_cnt = s_q.rise_cnt + 4'h1; // RULE11
                if (s_q.rise_cnt <= WORD_LAST) begin
                    s_d.word = wnext; // RULE14 RULE17
                end
                if (s_q.rise_cnt == WORD_LAST) begin
                    // Only the low channel bit steers the multiplexer
                    s_d.chan = wnext[CW_SEL_LO]; // RULE5 RULE6
                end
            end
            if (fall) begin
                s_d.fall_cnt = kfall;
                if (kfall == CLK_FIRST) begin
                    // Track starts; ask the core for the chosen input
                    s_d.phase = PH_TRACK; // RULE11 RULE16
                    s_d.track = 1'b1;
                    s_d.req = 1'b1; // RULE3
                    s_d.req_chan = s_q.chan;
                    s_d.seen_req = 1'b1;
                end
                if (kfall == CLK_HOLD) begin
                    s_d.phase = PH_CONV; // RULE16
                    s_d.track = 1'b0;
                end
                if (kfall < CLK_DATA) begin
                    s_d.dout = 1'b0; // RULE16
                end else if (kfall == CLK_DATA) begin
                    // Load oldest result, MSB goes out first
                    pop = bif.out_valid;
                    s_d.shift = bif.out_valid ? bif.out_data : CODE_ZERO;
                    s_d.dout = s_d.shift[RES_W-1]; // RULE8 RULE16
                end else begin
                    s_d.dout = s_q.shift[RES_W-2];
                    s_d.shift = {s_q.shift[RES_W-2:0], 1'b0};
                end
                if (kfall == CLK_LAST) begin
                    s_d.phase = PH_DOWN; // RULE10
                end
            end
        end
        s_d.pwr = cs_low & (s_d.phase != PH_DOWN); // RULE9 RULE10
        // Ready next cycle unless the buffer ends this cycle full
        s_d.rdy = pop | (bif.in_ready & ~(bif.out_valid & bif.in_valid));
        if (!CE) begin
            s_d = s_q;
            pop = 1'b0;
        end
    end

    // State register; first request after reset is input A
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            s_q <= '0;
            s_q.cs_s1 <= 1'b1;
            s_q.cs_s2 <= 1'b1;
            s_q.cs_p <= 1'b1;
            s_q.word <= CW_RESET;
            s_q.chan <= CHAN_A; // RULE4
            s_q.phase <= PH_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign DOUT = s_q.dout;
    assign DOUT_OE = s_q.oe;
    assign SAMPLE_REQ = s_q.req;
    assign SAMPLE_CHAN = s_q.req_chan;
    assign RESULT_READY = s_q.rdy;
    assign POWERED = s_q.pwr;
    assign TRACKING = s_q.track;

    // Checks on the sequencing
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    a_oe_released: assert property ( // RULE15
        CE && s_q.cs_s2 |=> !DOUT_OE)
        else $error("Output driven while frame select high");

    a_oe_driven: assert property ( // RULE15
        CE && !s_q.cs_s2 |=> DOUT_OE)
        else $error("Output not driven while frame select low");

    a_power_cs_high: assert property ( // RULE9
        CE && s_q.cs_s2 ##1 CE && s_q.cs_s2 |=> !POWERED)
        else $error("Powered while frame select high");

    a_power_down_16: assert property ( // RULE10
        fall && CE && s_q.fall_cnt == 5'h0f |=> !POWERED && !TRACKING)
        else $error("No power-down after last falling edge");

    a_first_chan_a: assert property ( // RULE4
        SAMPLE_REQ && !$past(s_q.seen_req) |-> SAMPLE_CHAN == CHAN_A)
        else $error("First request not for input A");

    a_first_frame: assert property ( // RULE3
        fall && CE && s_q.fall_cnt == CLK_NONE |=> SAMPLE_REQ && TRACKING)
        else $error("First frame did not start a conversion");

    a_chan_from_word: assert property ( // RULE5
        rise && CE && s_q.rise_cnt == WORD_LAST
        |=> s_q.chan == $past(s_q.word[CW_SEL_LO-1]))
        else $error("Channel not taken from word bit 3");

    a_din_shift_in: assert property ( // RULE14
        rise && CE && s_q.rise_cnt <= WORD_LAST
        |=> s_q.word[0] == $past(s_q.din_s2) ##0 s_q.rise_cnt != RISE_ZERO)
        else $error("Serial input not shifted on early rising edge");

    a_track_three: assert property ( // RULE16
        fall && CE && kfall == CLK_HOLD |=> !TRACKING && s_q.phase == PH_CONV)
        else $error("Track did not end at fourth falling edge");

    a_msb_first: assert property ( // RULE16
        fall && CE && kfall == CLK_DATA && bif.out_valid
        |=> DOUT == $past(bif.out_data[RES_W-1]))
        else $error("Result MSB not out on fifth clock");

    a_back_to_back: assert property ( // RULE11
        fall && CE && s_q.fall_cnt == CLK_LAST
        |=> SAMPLE_REQ && s_q.fall_cnt == CLK_FIRST)
        else $error("Next conversion did not follow");

    a_joint_fall: assert property ( // RULE2
        CE && cs_fell && !s_q.sck_s2
        |=> s_q.fall_cnt == CLK_FIRST && s_q.rise_cnt == RISE_ZERO)
        else $error("Joint fall not taken as first edge");

    // Counters restart whenever the frame is closed
    a_idle_counts: assert property ( // RULE2
        CE && s_q.cs_s2
        |=> s_q.fall_cnt == CLK_NONE && s_q.rise_cnt == RISE_ZERO)
        else $error("Counters not cleared outside a frame");

    a_word_frozen: assert property ( // RULE14
        rise && CE && s_q.rise_cnt > WORD_LAST |=> $stable(s_q.word))
        else $error("Control word changed after eighth rising edge");

    a_chan_hold: assert property ( // RULE5
        CE && !(rise && s_q.rise_cnt == WORD_LAST) |=> $stable(s_q.chan))
        else $error("Channel changed outside eighth rising edge");

    a_lead_zeros: assert property ( // RULE16
        fall && CE && kfall < CLK_DATA |=> !DOUT)
        else $error("Output not low before fifth clock");

    a_track_start: assert property ( // RULE16
        fall && CE && kfall == CLK_FIRST |=> TRACKING && POWERED)
        else $error("Track not started on first falling edge");

    a_down_held: assert property ( // RULE10
        CE && s_q.phase == PH_DOWN && !fall |=> !POWERED)
        else $error("Powered up again before next conversion");

    a_req_pulse: assert property ( // RULE11
        CE && SAMPLE_REQ |=> !SAMPLE_REQ)
        else $error("Sample request longer than one cycle");

    a_ready_honest: assert property ( // RULE11
        CE && RESULT_READY |-> bif.in_ready)
        else $error("Ready shown while buffer full");

    // Main scenarios
    c_two_convs: cover property (
        fall && CE && s_q.fall_cnt == CLK_LAST && !s_q.cs_s2);
    c_chan_b: cover property (SAMPLE_REQ && SAMPLE_CHAN == CHAN_B);
    c_buf_full: cover property (!RESULT_READY);
    c_result_out: cover property (pop);
    c_idle_high: cover property (
        fall && CE && s_q.fall_cnt == CLK_NONE && !cs_fell);

endmodule
`default_nettype wire

// ===== dca_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dca_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    // Observed status
    input wire logic powered,
    input wire logic tracking
);
    logic [15:0] dq [4];
    logic [15:0] pq [4];
    logic [15:0] tq [4];

    // Idle pins before the first frame
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // Half a serial period of 400 ns keeps the clock under its limit
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // One frame of n whole conversions, 16 rises each
    task automatic frame(input int n, input logic hi, input logic [31:0] w);
        logic [7:0] b;
        sclk = hi;
        half();
        cs_n = 1'b0;
        if (hi) half();
        for (int c = 0; c < n; c++) begin
            b = w[8*c +: 8];
            for (int k = 0; k < 16; k++) begin
                sclk = 1'b0;
                din = (k < 8) ? b[7-k] : ~b[3];
                half();
                sclk = 1'b1;
                half();
                dq[c][15-k] = dout;
                pq[c][15-k] = powered;
                tq[c][15-k] = tracking;
            end
        end
        half();
        cs_n = 1'b1;
        din = ~din;
    endtask
endmodule
`default_nettype wire

// ===== tb_dca_serial_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dca_serial_ctrl import dca_pkg::*;;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cs_n, sclk, din, dout, dout_oe, req, chan;
    logic rvalid, rready, powered, tracking, took;
    logic auto_core = 1'b1;
    logic ce = 1'b1;
    dca_code_t rcode;
    dca_code_t code_a = 12'h3c1;
    dca_code_t code_b = 12'ha5c;
    int miscompares = 0;
    int n_tests = 0;
    // Released output pin floats
    wire dout_w = dout_oe ? dout : 1'bz;

    initial forever #50 clk = ~clk;

    dca_serial_ctrl DUT (.CORE_CLK(clk), .RESET(reset), .CE(ce),
        .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout),
        .DOUT_OE(dout_oe), .SAMPLE_REQ(req), .SAMPLE_CHAN(chan),
        .RESULT_VALID(rvalid), .RESULT_CODE(rcode),
        .RESULT_READY(rready), .POWERED(powered), .TRACKING(tracking));

    dca_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout_w), .powered(powered), .tracking(tracking));

    // Converter core: answers each request, holds until taken
    initial begin
        rvalid = 1'b0;
        rcode = 12'h000;
    end
    always @(posedge clk) took <= rvalid && rready && ce;
    always @(negedge clk) begin
        if (took) begin
            rvalid = 1'b0;
            rcode = ~rcode;
        end
        if (auto_core && req) begin
            rvalid = 1'b1;
            rcode = chan ? code_b : code_a;
        end
    end

    // Compare a 16-bit capture
    task automatic cmp16(input logic [15:0] g, input logic [15:0] e,
                         input string s);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask

    // Compare a single flag
    task automatic cmp1(input logic g, input logic e, input string s);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, s, g, e);
        end
    endtask

    // Check one captured conversion
    task automatic chk_conv(input int c, input dca_code_t e);
        cmp16(host.dq[c], {4'h0, e}, "data");
        cmp16(host.pq[c], 16'hfffe, "power");
        cmp16(host.tq[c], 16'he000, "track");
    endtask

    // Pin released and powered down after a frame
    task automatic chk_idle();
        repeat (6) @(negedge clk);
        cmp1(dout_oe, 1'b0, "oe idle");
        cmp1(powered, 1'b0, "power idle");
    endtask

    // Push one result into the buffer by hand
    task automatic push(input dca_code_t v);
        @(negedge clk);
        rvalid = 1'b1;
        rcode = v;
        for (int i = 0; i < 20 && rvalid; i++) @(negedge clk);
    endtask

    // First frame after reset, select and clock fall together
    task automatic t_first();
        host.frame(3, 1'b0, 32'h000827c8);
        chk_conv(0, code_a);
        chk_conv(1, code_b);
        chk_conv(2, code_a);
        chk_idle();
        $display("test first_frame done");
    endtask

    // Clock idles high, end codes of the range
    task automatic t_idle_high();
        code_a = 12'h000;
        code_b = 12'hfff;
        host.frame(2, 1'b1, 32'h00000800);
        chk_conv(0, 12'hfff);
        chk_conv(1, 12'h000);
        chk_idle();
        $display("test idle_high done");
    endtask

    // Fill buffer until refused, then drain with the core stalled
    task automatic t_buffer();
        auto_core = 1'b0;
        // Frozen block must not take the word; a double store shows up
        ce = 1'b0;
        push(12'h111);
        ce = 1'b1;
        for (int i = 0; i < 4 && rvalid; i++) @(negedge clk);
        push(12'h222);
        @(negedge clk);
        rvalid = 1'b1;
        rcode = 12'h333;
        repeat (3) @(negedge clk);
        cmp1(rready, 1'b0, "full");
        host.frame(4, 1'b0, 32'h00000000);
        chk_conv(0, 12'h111);
        chk_conv(1, 12'h222);
        chk_conv(2, 12'h333);
        chk_conv(3, 12'h000);
        chk_idle();
        auto_core = 1'b1;
        $display("test buffer done");
    endtask

    // Report and end the run
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        t_first();
        t_idle_high();
        t_buffer();
        print_verdict();
    end

    // Watchdog well beyond the nine conversions run
    initial begin
        #2ms;
        miscompares++;
        $display("MISMATCH t=%0t watchdog", $time);
        print_verdict();
    end
endmodule
`default_nettype wire
